// ===== rtl/fsc_latency.sv
`timescale 1ns/1ps
module fsc_latency
   import fsc_pkg::*;
#(
   parameter int LAT_W = 3
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Read request
   input wire logic addr_latch,
   input wire logic sync_mode,
   input wire logic [LAT_W-1:0] latency,
   // Result
   output logic first_data
);

   initial begin
      if (LAT_W < 2 || LAT_W > 8) begin
         $error("fsc_latency: LAT_W out of range");
      end
   end

   typedef enum logic {
      FSC_LAT_IDLE = 1'b0,
      FSC_LAT_COUNT = 1'b1
   } fsc_lat_state_t;

   fsc_lat_state_t state_q;
   logic [LAT_W-1:0] count_q;
   logic first_q;

   // No bank or block gating: a burst may start anywhere
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_q <= FSC_LAT_IDLE;
         count_q <= '0;
         first_q <= 1'b0;
      end else begin
         first_q <= 1'b0;
         unique case (state_q)
            FSC_LAT_IDLE: begin
               if (addr_latch && sync_mode) begin
                  state_q <= FSC_LAT_COUNT;
                  count_q <= latency - LAT_W'(1);
               end
            end
            FSC_LAT_COUNT: begin
               if (count_q == '0) begin
                  first_q <= 1'b1;
                  state_q <= FSC_LAT_IDLE;
               end else begin
                  count_q <= count_q - LAT_W'(1);
               end
            end
         endcase
      end
   end

   assign first_data = first_q;

   // ****************************************
   // Assertions
   // ****************************************
   a_lat_two_cycles: assert property (@(posedge sys_clk) disable iff (reset)
      (state_q == FSC_LAT_IDLE && addr_latch && sync_mode && latency == 3'h2)
      |=> !first_data [*2] ##1 first_data)
      else $error("first data not two cycles after latch");
   a_lat_async_none: assert property (@(posedge sys_clk) disable iff (reset)
      (state_q == FSC_LAT_IDLE && !(addr_latch && sync_mode)) |=> !first_data)
      else $error("first data without synchronous latch");
   c_lat_five: cover property (@(posedge sys_clk) disable iff (reset)
      addr_latch && sync_mode && latency == 3'h5 ##6 first_data);

endmodule // fsc_latency

// ===== rtl/fsc_pkg.sv
package fsc_pkg;

   // ****************************************
   // Status byte layout
   // ****************************************
   localparam int STAT_READY = 7;
   localparam int STAT_ERASE_SUSP = 6;
   localparam int STAT_ERASE_FAIL = 5;
   localparam int STAT_PROG_FAIL = 4;
   localparam int STAT_SUPPLY = 3;
   localparam int STAT_PROG_SUSP = 2;
   localparam int STAT_PROTECT = 1;
   localparam int STAT_BANK = 0;

   // ****************************************
   // Configuration word layout
   // ****************************************
   localparam int CFG_READ_SEL = 15;
   localparam int CFG_LAT_HI = 13;
   localparam int CFG_LAT_LO = 11;
   localparam logic [15:0] CFG_RESET = 16'hbfcf;
   localparam logic CFG_ASYNC = 1'h1;
   localparam logic [2:0] LAT_MIN = 3'h2;
   localparam logic [2:0] LAT_MAX = 3'h5;

   // ****************************************
   // Command codes
   // ****************************************
   typedef enum logic [7:0] {
      FSC_CMD_CLR_STATUS = 8'h50,
      FSC_CMD_RESUME = 8'hd0,
      FSC_CMD_SET_CONFIG = 8'h03
   } fsc_cmd_t;

   // Controller event pulses, one cycle each
   typedef struct packed {
      logic erase_fail;
      logic program_fail;
      logic supply_invalid;
      logic prot_attempt;
      logic erase_suspended;
      logic program_suspended;
   } fsc_events_t;

   typedef struct packed {
      logic valid;
      fsc_cmd_t code;
      logic [15:0] data;
   } fsc_cmd_req_t;

   function automatic logic fsc_lat_defined(input logic [2:0] code);
      return (code >= LAT_MIN) && (code <= LAT_MAX);
   endfunction

endpackage

// ===== rtl/fsc_status_config.sv
`timescale 1ns/1ps
module fsc_status_config
   import fsc_pkg::*;
#(
   parameter int BANK_W = 3
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Command interface
   input wire fsc_cmd_req_t cmd,
   // Program/erase controller
   input wire logic pec_busy,
   input wire logic [BANK_W-1:0] op_bank,
   input wire logic [BANK_W-1:0] addr_bank,
   input wire logic fast_factory_program_mode,
   input wire logic efp_word_busy,
   input wire fsc_events_t events,
   // Read path
   input wire logic addr_latch,
   // Outputs
   output logic [7:0] operation_status_word,
   output logic [15:0] bus_read_configuration,
   output logic read_sync,
   output logic first_data,
   output logic op_abort,
   output logic latency_undefined
);

   initial begin
      if (BANK_W < 1 || BANK_W > 6) begin
         $error("fsc_status_config: BANK_W out of range");
      end
   end

   // ****************************************
   // Command decode
   // ****************************************
   logic clr_status;
   logic resume;
   logic set_cfg;
   assign clr_status = cmd.valid && cmd.code == FSC_CMD_CLR_STATUS;
   assign resume = cmd.valid && cmd.code == FSC_CMD_RESUME;
   assign set_cfg = cmd.valid && cmd.code == FSC_CMD_SET_CONFIG;

   // ****************************************
   // Sticky error flags
   // ****************************************
   logic erase_fail_flag_q;
   logic program_fail_flag_q;
   logic supply_invalid_flag_q;
   logic protection_violation_flag_q;

   // Set wins over a clear in the same cycle
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         erase_fail_flag_q <= 1'b0;
         program_fail_flag_q <= 1'b0;
         supply_invalid_flag_q <= 1'b0;
         protection_violation_flag_q <= 1'b0;
      end else begin
         erase_fail_flag_q <= events.erase_fail
            || (erase_fail_flag_q && !clr_status);
         program_fail_flag_q <= events.program_fail
            || (program_fail_flag_q && !clr_status);
         supply_invalid_flag_q <= events.supply_invalid
            || (supply_invalid_flag_q && !clr_status);
         protection_violation_flag_q <= events.prot_attempt
            || (protection_violation_flag_q && !clr_status);
      end
   end

   // Abort tells the controller to drop the locked-block operation
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         op_abort <= 1'b0;
      end else begin
         op_abort <= events.prot_attempt;
      end
   end

   // ****************************************
   // Suspend flags
   // ****************************************
   logic erase_suspend_flag_q;
   logic program_suspend_flag_q;

   // Suspend event wins over a resume in the same cycle
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         erase_suspend_flag_q <= 1'b0;
         program_suspend_flag_q <= 1'b0;
      end else begin
         erase_suspend_flag_q <= events.erase_suspended
            || (erase_suspend_flag_q && !resume);
         program_suspend_flag_q <= events.program_suspended
            || (program_suspend_flag_q && !resume);
      end
   end

   // ****************************************
   // Ready and bank write flags
   // ****************************************
   logic controller_ready_flag;
   logic bank_write_flag;
   assign controller_ready_flag = !pec_busy;

   always_comb begin
      if (fast_factory_program_mode) begin
         // High only while busy with the current word
         bank_write_flag = pec_busy && efp_word_busy;
      end else begin
         // Compared against the addressed bank only
         bank_write_flag = pec_busy && (op_bank != addr_bank);
      end
   end

   logic [7:0] status_d;
   always_comb begin
      status_d = '0;
      status_d[STAT_READY] = controller_ready_flag;
      status_d[STAT_ERASE_SUSP] = erase_suspend_flag_q;
      status_d[STAT_ERASE_FAIL] = erase_fail_flag_q;
      status_d[STAT_PROG_FAIL] = program_fail_flag_q;
      status_d[STAT_SUPPLY] = supply_invalid_flag_q;
      status_d[STAT_PROG_SUSP] = program_suspend_flag_q;
      status_d[STAT_PROTECT] = protection_violation_flag_q;
      status_d[STAT_BANK] = bank_write_flag;
   end

   // Registered so the byte is stable across the read strobe
   logic [7:0] status_q;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         // Idle after reset: only the ready bit up
         status_q <= 8'(1) << STAT_READY;
      end else begin
         status_q <= status_d;
      end
   end
   assign operation_status_word = status_q;

   // ****************************************
   // Configuration register
   // ****************************************
   logic [15:0] config_q;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         config_q <= CFG_RESET;
      end else if (set_cfg) begin
         config_q <= cmd.data;
      end
   end
   assign bus_read_configuration = config_q;

   logic [2:0] lat_code;
   assign lat_code = config_q[CFG_LAT_HI:CFG_LAT_LO];
   assign read_sync = config_q[CFG_READ_SEL] != CFG_ASYNC;
   // Undefined codes are stored but flagged; the host must avoid them
   assign latency_undefined = !fsc_lat_defined(lat_code);

   fsc_latency #(
      .LAT_W(3)
   ) u_latency (
      .sys_clk(sys_clk),
      .reset(reset),
      .addr_latch(addr_latch),
      .sync_mode(read_sync),
      .latency(lat_code),
      .first_data(first_data)
   );

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   a_bank_other_busy: assert property (
      pec_busy && !fast_factory_program_mode && op_bank != addr_bank
      |=> operation_status_word[STAT_BANK] && !operation_status_word[STAT_READY])
      else $error("other bank busy not reported");
   a_idle_all_clear: assert property (
      !pec_busy |=> operation_status_word[STAT_READY] && !operation_status_word[STAT_BANK])
      else $error("idle device shows bank write");
   a_bank_own_busy: assert property (
      pec_busy && !fast_factory_program_mode && op_bank == addr_bank
      |=> !operation_status_word[STAT_BANK] && !operation_status_word[STAT_READY])
      else $error("addressed bank busy not reported");
   a_efp_word_busy: assert property (
      pec_busy && fast_factory_program_mode && efp_word_busy
      |=> operation_status_word[STAT_BANK])
      else $error("fast program busy not shown");
   a_efp_next_word: assert property (
      pec_busy && fast_factory_program_mode && !efp_word_busy
      |=> !operation_status_word[STAT_BANK] && !operation_status_word[STAT_READY])
      else $error("fast program ready not shown");
   a_efp_exit: assert property (
      !pec_busy && fast_factory_program_mode
      |=> !operation_status_word[STAT_BANK] && operation_status_word[STAT_READY])
      else $error("fast program exit not shown");
   a_protect_abort: assert property (
      events.prot_attempt |=> op_abort ##1 operation_status_word[STAT_PROTECT])
      else $error("locked attempt not flagged");
   a_protect_quiet: assert property (
      !protection_violation_flag_q && !events.prot_attempt |=> !protection_violation_flag_q)
      else $error("protection flag set without cause");
   a_prog_susp_low: assert property (
      !program_suspend_flag_q && !events.program_suspended |=> !program_suspend_flag_q)
      else $error("program suspend set without suspend");
   a_config_hold: assert property (
      !set_cfg |=> $stable(bus_read_configuration))
      else $error("configuration changed without command");
   a_config_load: assert property (
      set_cfg |=> bus_read_configuration == $past(cmd.data))
      else $error("configuration not loaded");
   a_read_select: assert property (
      read_sync == !bus_read_configuration[CFG_READ_SEL])
      else $error("read select decode wrong");
   a_error_sticky: assert property (
      erase_fail_flag_q && !clr_status |=> erase_fail_flag_q [*2] or
      (erase_fail_flag_q ##1 clr_status))
      else $error("erase fail flag dropped");
   a_error_clear: assert property (
      clr_status && !events.program_fail |=> !program_fail_flag_q)
      else $error("clear status ignored");
   a_resume_clear: assert property (
      resume && !events.erase_suspended |=> !erase_suspend_flag_q ##1
      !operation_status_word[STAT_ERASE_SUSP])
      else $error("resume did not clear erase suspend");
   a_ready_bit: assert property (
      pec_busy |=> !operation_status_word[STAT_READY])
      else $error("ready flag high while busy");

   c_other_bank: cover property (pec_busy && op_bank != addr_bank);
   c_protect: cover property (events.prot_attempt ##2 clr_status);
   c_sync_cfg: cover property (set_cfg && !cmd.data[CFG_READ_SEL]);
   c_resume: cover property (erase_suspend_flag_q && resume);

endmodule // fsc_status_config

// ===== tb/fsc_host_model.sv
`timescale 1ns/1ps
module fsc_host_model
   import fsc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Request from bench
   input wire logic send,
   input wire fsc_cmd_t code,
   input wire logic [15:0] data,
   // Command to device
   output fsc_cmd_req_t cmd
);
   logic [15:0] last_q;
   logic lat_ok;

   // Host only writes codes that suit its clock period
   assign lat_ok = (data[13:11] >= LAT_MIN) && (data[13:11] <= LAT_MAX);

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         last_q <= 16'h0000;
      end else if (send) begin
         last_q <= data;
      end
   end

   // Idle lines toggle, so a stale word never looks valid
   always_comb begin
      cmd.valid = send && ((code != FSC_CMD_SET_CONFIG) || lat_ok);
      cmd.code = send ? code : fsc_cmd_t'(~last_q[7:0]);
      cmd.data = send ? data : ~last_q;
   end
endmodule // fsc_host_model

// ===== tb/fsc_status_config_tb_top.sv
`timescale 1ns/1ps
module fsc_status_config_tb_top
   import fsc_pkg::*;
;
   typedef struct {int kind; logic [15:0] exp; int due;} fsc_note_t;
   logic sys_clk, reset, pec_busy, ffp, efp_busy, addr_latch, send;
   logic read_sync, first_data, op_abort, lat_undef;
   logic [2:0] op_bank, addr_bank;
   logic [7:0] status;
   logic [15:0] cfg, data, last_cfg;
   logic [31:0] seed, r;
   fsc_events_t events;
   fsc_cmd_t code;
   fsc_cmd_req_t cmd;
   int n_fail, checks_done, cyc;
   fsc_note_t noteq[$];
   int latq[$];
   string names[4] = '{"status", "config", "abort", "mode"};

   fsc_host_model fsc_host_model_i (.sys_clk(sys_clk), .reset(reset), .send(send),
      .code(code), .data(data), .cmd(cmd));
   fsc_status_config fsc_status_config_i (.sys_clk(sys_clk), .reset(reset), .cmd(cmd),
      .pec_busy(pec_busy), .op_bank(op_bank), .addr_bank(addr_bank),
      .fast_factory_program_mode(ffp), .efp_word_busy(efp_busy), .events(events),
      .addr_latch(addr_latch), .operation_status_word(status), .bus_read_configuration(cfg),
      .read_sync(read_sync), .first_data(first_data), .op_abort(op_abort),
      .latency_undefined(lat_undef));

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [15:0] obs(int k);
      case (k)
         0: return {8'h00, status};
         1: return cfg;
         2: return {15'h0000, op_abort};
         default: return {14'h0000, read_sync, lat_undef};
      endcase
   endfunction

   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic note(int kind, logic [15:0] exp, int dly);
      noteq.push_back('{kind, exp, cyc + dly});
   endtask

   task automatic step(int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ****************************************
   // Clock, cycle count, monitor
   // ****************************************
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) cyc <= cyc + 1;

   always @(negedge sys_clk) begin
      fsc_note_t n;
      while (noteq.size() > 0 && noteq[0].due <= cyc) begin
         n = noteq.pop_front();
         check(names[n.kind], obs(n.kind), n.exp);
      end
      if (first_data === 1'b1) begin
         if (latq.size() == 0) check("first data", 16'h0000, 16'h0001);
         else check("first data", 16'(cyc), 16'(latq.pop_front()));
      end
   end

   initial begin
      #(5ns * 2000);
      n_fail++;
      $display("watchdog expired");
      final_report();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {pec_busy, ffp, efp_busy, addr_latch, send, op_bank, addr_bank} = '0;
      events = '0;
      code = FSC_CMD_CLR_STATUS;
      data = 16'h0000;
      seed = 32'hf8f6cc08;
      n_fail = 0;
      checks_done = 0;
      cyc = 0;
      reset = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1 reset = 1'b0;
      note(0, 16'h0080, 0);
      note(1, CFG_RESET, 0);
      note(3, 16'h0001, 0);
      step(2);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         r = xs();
         pec_busy = i[1];
         op_bank = r[2:0];
         addr_bank = i[0] ? op_bank : op_bank ^ (r[5:3] | 3'h1);
         note(0, {8'h00, ~pec_busy, 6'h00, pec_busy && (op_bank != addr_bank)}, 1);
         step(2);
      end
      $display("test bank flag done");
      ffp = 1'b1;
      addr_bank = op_bank;
      for (int i = 0; i < 3; i++) begin
         pec_busy = (i < 2);
         efp_busy = (i == 0);
         note(0, (i == 0) ? 16'h0001 : (i == 1) ? 16'h0000 : 16'h0080, 1);
         step(2);
      end
      ffp = 1'b0;
      $display("test fast program done");
      events.prot_attempt = 1'b1;
      note(2, 16'h0001, 1);
      step(1);
      events = '0;
      note(2, 16'h0000, 1);
      note(0, 16'h0082, 1);
      step(2);
      events = fsc_events_t'(6'h3f);
      step(1);
      events = '0;
      step(4);
      note(0, 16'h00fe, 0);
      code = FSC_CMD_RESUME;
      send = 1'b1;
      step(1);
      send = 1'b0;
      note(0, 16'h00ba, 1);
      step(2);
      code = FSC_CMD_CLR_STATUS;
      send = 1'b1;
      step(1);
      send = 1'b0;
      note(0, 16'h0080, 1);
      step(2);
      $display("test flags done");
      for (int c = 2; c <= 5; c++) begin
         r = xs();
         data = {1'b0, r[14], 3'(c), r[10:0]};
         last_cfg = data;
         code = FSC_CMD_SET_CONFIG;
         send = 1'b1;
         note(1, data, 1);
         note(3, 16'h0002, 1);
         step(1);
         send = 1'b0;
         step(2);
         addr_latch = 1'b1;
         // Latched at the next edge, first data c edges after that
         latq.push_back(cyc + c + 1);
         step(1);
         addr_latch = 1'b0;
         addr_bank = addr_bank + 3'h1;
         step(8);
      end
      data = {1'b0, 1'b0, 3'h7, 11'h7ff};
      send = 1'b1;
      step(1);
      send = 1'b0;
      note(1, last_cfg, 1);
      step(2);
      $display("test config done");
      reset = 1'b1;
      note(1, CFG_RESET, 1);
      note(0, 16'h0080, 1);
      note(3, 16'h0001, 1);
      step(2);
      reset = 1'b0;
      note(1, CFG_RESET, 2);
      note(3, 16'h0001, 2);
      step(3);
      check("first data count", 16'(latq.size()), 16'h0000);
      $display("test second reset done");
      final_report();
   end
endmodule // fsc_status_config_tb_top
